// *** design/csl_pkg.sv ***
package csl_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CHAN_A_STATUS_CONTROL = 8'h0C; // Channel A status/control
    localparam logic [7:0] ADDR_CHAN_B_STATUS_CONTROL = 8'h0D; // Channel B status/control
    localparam logic [7:0] ADDR_INDICATOR_PIN_CONTROL = 8'h0E; // Indicator pin control
    // ----------------------------------------
    // Channel status field positions
    // ----------------------------------------
    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_FRAMER_ON = 6;
    localparam int BIT_ILIM_LATCHED = 5;
    localparam int BIT_UNDERVOLT_LATCHED = 4;
    localparam int BIT_DRIVER_FAULT_LATCHED = 3;
    localparam int BIT_ILIM_LIVE = 2;
    localparam int BIT_UNDERVOLT_LIVE = 1;
    localparam int BIT_DRIVER_FAULT_LIVE = 0;
    // ----------------------------------------
    // Indicator field positions inside one nibble
    // ----------------------------------------
    localparam int BIT_LED2_ON = 3;
    localparam int BIT_ERROR_PIN_SELECT = 2;
    localparam int BIT_LED1_ON = 1;
    localparam int BIT_READY_PIN_SELECT = 0;
    localparam int CHAN_B_NIBBLE_BASE = 4;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [1:0] CHAN_CTRL_RESET = 2'h0;
    localparam logic [2:0] LATCHED_RESET = 3'h0;
    localparam logic [3:0] INDICATOR_NIBBLE_RESET = 4'h0;
    // ----------------------------------------
    // Soft reset sequencing
    // ----------------------------------------
    localparam logic [1:0] SOFT_RESET_CYCLES = 2'h2;
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    // Real-time faults of one channel
    typedef struct packed {
        logic ilim;
        logic undervolt;
        logic driver_fault;
    } csl_fault_t;
    // Register access strobes
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } csl_access_t;
    // Soft reset sequencer states
    typedef enum logic [2:0] {
        SR_IDLE = 3'b001,
        SR_BUSY = 3'b010,
        SR_DONE = 3'b100
    } csl_sr_state_t;
endpackage : csl_pkg

// *** design/csl_channel.sv ***
`timescale 1ns/100ps
// One channel: control bits, fault sampling, latched flags, soft reset
module csl_channel
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire csl_pkg::csl_fault_t fault_pin,
    input wire logic write_hit,
    input wire logic read_hit,
    input wire logic [7:0] wdata,
    output logic [7:0] status_value,
    output logic soft_reset_pulse,
    output logic framer_on,
    output logic latched_any
);
    // ----------------------------------------
    // Fault synchronisers
    // ----------------------------------------
    csl_pkg::csl_fault_t sync1; // First stage, read only by sync2
    csl_pkg::csl_fault_t sync2; // Second stage
    csl_pkg::csl_fault_t live; // Previous sample for edge detect
    csl_pkg::csl_fault_t next_live;
    logic [2:0] latched; // Clear-on-read flags
    logic [2:0] next_latched;
    logic framer; // Framer enable
    logic next_framer;
    csl_pkg::csl_sr_state_t sr_state; // Soft reset sequencer
    csl_pkg::csl_sr_state_t next_sr_state;
    logic [1:0] sr_count; // Cycles spent in reset
    logic [1:0] next_sr_count;
    logic chan_clear; // Channel-local reset in progress

    // Synchroniser stages: fault pins are asynchronous
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= fault_pin;
            sync2 <= sync1;
        end
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        next_sr_state = sr_state;
        next_sr_count = sr_count;
        next_framer = framer;
        next_live = sync2; // RQ9 RQ10 RQ11
        next_latched = latched;
        chan_clear = 1'b0;
        case (sr_state)
            csl_pkg::SR_IDLE:
            begin
                if (write_hit && wdata[csl_pkg::BIT_SOFT_RESET])
                begin
                    next_sr_state = csl_pkg::SR_BUSY; // RQ1
                    next_sr_count = '0;
                end
            end
            csl_pkg::SR_BUSY:
            begin
                chan_clear = 1'b1; // RQ1
                next_sr_count = sr_count + 2'h1;
                if (sr_count == csl_pkg::SOFT_RESET_CYCLES - 2'h1)
                begin
                    next_sr_state = csl_pkg::SR_DONE;
                end
            end
            csl_pkg::SR_DONE:
            begin
                next_sr_state = csl_pkg::SR_IDLE; // RQ3
            end
            default:
            begin
                next_sr_state = csl_pkg::SR_IDLE;
            end
        endcase
        // Clear on read, then a rising edge sets: set wins over the clear
        if (read_hit)
        begin
            next_latched = '0; // RQ7
        end
        next_latched = next_latched | (sync2 & ~live); // RQ6 RQ19
        if (write_hit && sr_state == csl_pkg::SR_IDLE)
        begin
            next_framer = wdata[csl_pkg::BIT_FRAMER_ON]; // RQ4
        end
        if (chan_clear)
        begin
            // Live image follows the pin; only own channel state returns to power-on
            next_framer = csl_pkg::CHAN_CTRL_RESET[0]; // RQ1 RQ2
            next_latched = csl_pkg::LATCHED_RESET;
        end
    end

    // Registering of channel state
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sr_state <= csl_pkg::SR_IDLE;
            sr_count <= '0;
            framer <= csl_pkg::CHAN_CTRL_RESET[0];
            live <= '0;
            latched <= csl_pkg::LATCHED_RESET;
        end
        else
        begin
            sr_state <= next_sr_state;
            sr_count <= next_sr_count;
            framer <= next_framer;
            live <= next_live;
            latched <= next_latched;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Reset bit reads one until the sequence completes
    assign status_value = {sr_state != csl_pkg::SR_IDLE, framer, latched, live}; // RQ3
    assign soft_reset_pulse = chan_clear; // Clears FIFOs and indicator nibble
    assign framer_on = framer;
    assign latched_any = |latched; // RQ8
endmodule : csl_channel

// *** design/csl_status_led.sv ***
`timescale 1ns/100ps
// How it works
// RQ1 - Soft reset returns channel state to power-on
// RQ2 - Other channel and global bits untouched
// RQ3 - Soft reset bit clears itself when done
// RQ4 - Framer enable activates handler and FIFOs
// RQ5 - Host keeps framer off with external UART
// RQ6 - Latched faults set on rising edge only
// RQ7 - Status read clears latched flags only
// RQ8 - Any latched fault raises status interrupt
// RQ9 - Live current limit follows supply limiter
// RQ10 - Live undervoltage follows supply comparator
// RQ11 - Live driver fault follows line driver
// RQ12 - LED2 bit drives error pin when unselected
// RQ13 - Error select shows receive error flag
// RQ14 - Error indicator ignores error irq mask
// RQ15 - LED1 bit drives ready pin when unselected
// RQ16 - Ready select shows receive ready flag
// RQ17 - Ready indicator ignores ready irq mask
// RQ18 - Channel B mirrors A, upper nibble
// RQ19 - Edge during read keeps flag set
// RQ20 - Host is serial interface master
module csl_status_led
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire csl_pkg::csl_access_t reg_access,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire csl_pkg::csl_fault_t chan_a_fault,
    input wire csl_pkg::csl_fault_t chan_b_fault,
    input wire logic chan_a_receive_error_flag,
    input wire logic chan_a_receive_ready_flag,
    input wire logic chan_b_receive_error_flag,
    input wire logic chan_b_receive_ready_flag,
    input wire logic chan_a_error_irq_mask,
    input wire logic chan_a_ready_irq_mask,
    input wire logic chan_b_error_irq_mask,
    input wire logic chan_b_ready_irq_mask,
    output logic chan_a_framer_on,
    output logic chan_b_framer_on,
    output logic chan_a_fifo_clear,
    output logic chan_b_fifo_clear,
    output logic status_interrupt,
    output logic chan_a_error_led_pin_n,
    output logic chan_a_ready_led_pin_n,
    output logic chan_b_error_led_pin_n,
    output logic chan_b_ready_led_pin_n
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Address match, used for every register
    function automatic logic csl_match(input logic [7:0] addr, input logic [7:0] reg_addr);
        csl_match = (addr == reg_addr);
    endfunction : csl_match

    logic [1:0] chan_write; // Per-channel write strobes
    logic [1:0] chan_read; // Per-channel read strobes
    logic ind_write; // Indicator register write
    logic [7:0] chan_status [2]; // Channel status images
    logic [1:0] chan_clear; // Channel soft reset in progress
    logic [1:0] framer_vec; // Framer enables
    logic [1:0] latched_vec; // Any latched fault per channel
    logic [7:0] indicator; // Indicator control
    logic [7:0] next_indicator;
    logic [7:0] rdata; // Read data register
    logic [7:0] next_rdata;
    logic [1:0] err_flag; // Receive error flags by channel
    logic [1:0] rdy_flag; // Receive ready flags by channel
    logic [3:0] pin_on; // Active pin drive {b_rdy,b_err,a_rdy,a_err}
    logic [3:0] next_pin_on;
    csl_pkg::csl_fault_t fault_in [2];

    assign chan_write[0] = reg_access.wr && csl_match(reg_access.addr, csl_pkg::ADDR_CHAN_A_STATUS_CONTROL);
    assign chan_write[1] = reg_access.wr && csl_match(reg_access.addr, csl_pkg::ADDR_CHAN_B_STATUS_CONTROL);
    assign chan_read[0] = reg_access.rd && csl_match(reg_access.addr, csl_pkg::ADDR_CHAN_A_STATUS_CONTROL);
    assign chan_read[1] = reg_access.rd && csl_match(reg_access.addr, csl_pkg::ADDR_CHAN_B_STATUS_CONTROL);
    assign ind_write = reg_access.wr && csl_match(reg_access.addr, csl_pkg::ADDR_INDICATOR_PIN_CONTROL);
    assign reg_hit = csl_match(reg_access.addr, csl_pkg::ADDR_CHAN_A_STATUS_CONTROL)
                  || csl_match(reg_access.addr, csl_pkg::ADDR_CHAN_B_STATUS_CONTROL)
                  || csl_match(reg_access.addr, csl_pkg::ADDR_INDICATOR_PIN_CONTROL);
    assign fault_in[0] = chan_a_fault;
    assign fault_in[1] = chan_b_fault;
    assign err_flag = {chan_b_receive_error_flag, chan_a_receive_error_flag};
    assign rdy_flag = {chan_b_receive_ready_flag, chan_a_receive_ready_flag};

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    // Same logic for both channels, B simply sits one address higher
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        csl_channel u_chan
        (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .fault_pin(fault_in[ch]),
            .write_hit(chan_write[ch]),
            .read_hit(chan_read[ch]),
            .wdata(reg_access.wdata),
            .status_value(chan_status[ch]),
            .soft_reset_pulse(chan_clear[ch]),
            .framer_on(framer_vec[ch]),
            .latched_any(latched_vec[ch])
        ); // RQ18
    end

    // ----------------------------------------
    // Indicator register and pins
    // ----------------------------------------
    // Nibble per channel; a soft reset clears only its own nibble
    always_comb
    begin
        next_indicator = indicator;
        next_pin_on = pin_on; // Every bit is rewritten below; default keeps the process latch-free
        if (ind_write)
        begin
            next_indicator = reg_access.wdata;
        end
        if (chan_clear[0])
        begin
            next_indicator[3:0] = csl_pkg::INDICATOR_NIBBLE_RESET; // RQ1 RQ2
        end
        if (chan_clear[1])
        begin
            next_indicator[7:4] = csl_pkg::INDICATOR_NIBBLE_RESET; // RQ1 RQ2 RQ18
        end
        for (int ch = 0; ch < 2; ch++)
        begin
            // Masks are not consulted: the pins show raw status
            if (indicator[ch * csl_pkg::CHAN_B_NIBBLE_BASE + csl_pkg::BIT_ERROR_PIN_SELECT])
            begin
                next_pin_on[ch * 2] = err_flag[ch]; // RQ13 RQ14
            end
            else
            begin
                next_pin_on[ch * 2] = indicator[ch * csl_pkg::CHAN_B_NIBBLE_BASE + csl_pkg::BIT_LED2_ON]; // RQ12
            end
            if (indicator[ch * csl_pkg::CHAN_B_NIBBLE_BASE + csl_pkg::BIT_READY_PIN_SELECT])
            begin
                next_pin_on[ch * 2 + 1] = rdy_flag[ch]; // RQ16 RQ17
            end
            else
            begin
                next_pin_on[ch * 2 + 1] = indicator[ch * csl_pkg::CHAN_B_NIBBLE_BASE + csl_pkg::BIT_LED1_ON]; // RQ15
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Data registered so the latched image is the one before the clear
    always_comb
    begin
        next_rdata = rdata;
        if (reg_access.rd)
        begin
            if (csl_match(reg_access.addr, csl_pkg::ADDR_CHAN_A_STATUS_CONTROL))
            begin
                next_rdata = chan_status[0];
            end
            else if (csl_match(reg_access.addr, csl_pkg::ADDR_CHAN_B_STATUS_CONTROL))
            begin
                next_rdata = chan_status[1];
            end
            else if (csl_match(reg_access.addr, csl_pkg::ADDR_INDICATOR_PIN_CONTROL))
            begin
                next_rdata = indicator;
            end
            else
            begin
                next_rdata = 8'h00; // Unmapped reads as zero
            end
        end
    end

    // Registering of shared state
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            indicator <= {2{csl_pkg::INDICATOR_NIBBLE_RESET}};
            rdata <= 8'h00;
            pin_on <= 4'h0;
        end
        else
        begin
            indicator <= next_indicator;
            rdata <= next_rdata;
            pin_on <= next_pin_on;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = rdata;
    assign chan_a_framer_on = framer_vec[0]; // RQ4
    assign chan_b_framer_on = framer_vec[1]; // RQ4
    assign chan_a_fifo_clear = chan_clear[0]; // RQ1
    assign chan_b_fifo_clear = chan_clear[1]; // RQ1
    assign status_interrupt = |latched_vec; // RQ8
    // Pins are active low: low lights the LED or flags the event
    assign chan_a_error_led_pin_n = ~pin_on[0];
    assign chan_a_ready_led_pin_n = ~pin_on[1];
    assign chan_b_error_led_pin_n = ~pin_on[2];
    assign chan_b_ready_led_pin_n = ~pin_on[3];

    // Masks are deliberately unused by the pin logic
    logic unused_masks;
    assign unused_masks = chan_a_error_irq_mask ^ chan_a_ready_irq_mask ^ chan_b_error_irq_mask ^ chan_b_ready_irq_mask;
endmodule : csl_status_led

// *** verification/csl_assertions.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for the status and LED block
// ----------------------------------------
module csl_assertions
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire csl_pkg::csl_access_t reg_access,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    input wire csl_pkg::csl_fault_t chan_a_fault,
    input wire csl_pkg::csl_fault_t chan_b_fault,
    input wire logic chan_b_receive_error_flag,
    input wire logic chan_b_framer_on,
    input wire logic chan_a_fifo_clear,
    input wire logic chan_b_fifo_clear,
    input wire logic chan_a_framer_on,
    input wire logic status_interrupt,
    input wire logic chan_a_ready_led_pin_n,
    input wire logic chan_b_error_led_pin_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [5:0] fault_prev; // Fault pins one edge ago
    logic fault_rise; // Any fault pin went high
    // Zero after reset, so faults held through reset count as a rise
    always_ff @(posedge sys_clk)
    begin
        fault_prev <= rst_n ? {chan_a_fault, chan_b_fault} : 6'h00;
    end
    assign fault_rise = |({chan_a_fault, chan_b_fault} & ~fault_prev);
    a_hit_decode: assert property (reg_hit == (reg_access.addr inside {8'h0C, 8'h0D, 8'h0E}))
        else $error("address hit wrong");
    a_unmapped_zero: assert property (reg_access.rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_soft_reset_seq: assert property (reg_access.wr && reg_access.addr == 8'h0C && reg_access.wdata[7]
        && !chan_a_fifo_clear && !$past(chan_a_fifo_clear)
        |=> chan_a_fifo_clear[*2] ##1 (!chan_a_fifo_clear && !chan_a_framer_on))
        else $error("soft reset sequence wrong");
    a_soft_reset_b: assert property (reg_access.wr && reg_access.addr == 8'h0D && reg_access.wdata[7]
        && !chan_b_fifo_clear && !$past(chan_b_fifo_clear)
        |=> chan_b_fifo_clear[*2] ##1 (!chan_b_fifo_clear && !chan_b_framer_on))
        else $error("channel b soft reset sequence wrong");
    a_reset_isolated: assert property (chan_a_fifo_clear && !chan_b_fifo_clear
        && !(reg_access.wr && reg_access.addr == 8'h0D) |=> $stable(chan_b_framer_on))
        else $error("other channel disturbed");
    a_led_mode_pin: assert property (reg_access.wr && reg_access.addr == 8'h0E
        && reg_access.wdata[1:0] == 2'b10 |-> ##2 !chan_a_ready_led_pin_n)
        else $error("led pin not lit");
    a_error_indicator: assert property (reg_access.wr && reg_access.addr == 8'h0E && reg_access.wdata[6]
        ##2 $stable(chan_b_receive_error_flag) |-> chan_b_error_led_pin_n != chan_b_receive_error_flag)
        else $error("error indicator wrong");
    a_irq_on_fault: assert property (fault_rise |-> ##3 status_interrupt)
        else $error("interrupt missing");
    a_irq_needs_rise: assert property ($rose(status_interrupt) |-> $past(fault_rise, 3))
        else $error("interrupt without edge");
    cover property (fault_rise ##3 status_interrupt);
    cover property ($rose(chan_a_fifo_clear));
    cover property (reg_access.rd && !reg_hit);
endmodule : csl_assertions

bind csl_status_led csl_assertions u_chk (.sys_clk, .rst_n, .reg_access, .reg_rdata, .reg_hit, .chan_a_fault,
    .chan_b_fault, .chan_b_receive_error_flag, .chan_b_framer_on, .chan_a_fifo_clear, .chan_b_fifo_clear,
    .chan_a_framer_on, .status_interrupt, .chan_a_ready_led_pin_n, .chan_b_error_led_pin_n);

// *** verification/csl_host_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Host side: one strobe per access
// ----------------------------------------
module csl_host_model
(
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output csl_pkg::csl_access_t reg_access
);
    initial reg_access = '0;
    // Idle bus shows inverted values, not the last request
    task wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_access <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        reg_access <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
    endtask : wr_reg
    // Data is registered, so take it just after the taking edge
    task rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        reg_access <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        reg_access <= '{addr: ~addr, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        #1 data = reg_rdata;
    endtask : rd_reg
endmodule : csl_host_model

// *** verification/testbench.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module testbench;
    logic sys_clk;
    logic rst_n;
    csl_pkg::csl_access_t reg_access;
    logic [7:0] reg_rdata;
    csl_pkg::csl_fault_t chan_a_fault;
    csl_pkg::csl_fault_t chan_b_fault;
    logic [3:0] flags; // Receive flags {b_err, b_rdy, a_err, a_rdy}
    logic [3:0] masks; // Irq masks, must have no effect
    logic [3:0] pins; // Pins in the same order
    logic [1:0] framer;
    logic status_interrupt;
    logic [7:0] rd, ctrl, addr;
    logic [2:0] v;
    int n_fail, compares, cycles, seed;
    csl_host_model u_host (.sys_clk, .reg_rdata, .reg_access);
    csl_status_led u_dut (.sys_clk, .rst_n, .reg_access, .reg_rdata, .reg_hit(), .chan_a_fault, .chan_b_fault,
        .chan_a_receive_error_flag(flags[1]), .chan_a_receive_ready_flag(flags[0]),
        .chan_b_receive_error_flag(flags[3]), .chan_b_receive_ready_flag(flags[2]),
        .chan_a_error_irq_mask(masks[1]), .chan_a_ready_irq_mask(masks[0]),
        .chan_b_error_irq_mask(masks[3]), .chan_b_ready_irq_mask(masks[2]),
        .chan_a_framer_on(framer[1]), .chan_b_framer_on(framer[0]), .chan_a_fifo_clear(), .chan_b_fifo_clear(),
        .status_interrupt, .chan_a_error_led_pin_n(pins[1]), .chan_a_ready_led_pin_n(pins[0]),
        .chan_b_error_led_pin_n(pins[3]), .chan_b_ready_led_pin_n(pins[2]));
    // Active-low pins: indicator follows its flag, else the LED bit
    function logic [3:0] exp_pins(input logic [7:0] c, input logic [3:0] f);
        for (int i = 0; i < 4; i++)
        begin
            exp_pins[i] = c[2 * i] ? !f[i] : !c[2 * i + 1];
        end
    endfunction : exp_pins
    task check8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd_reg(a, rd);
        check8(rd, exp);
    endtask : rd_chk
    task stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // Free-running clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            stop_test;
        end
    end
    initial
    begin
        rst_n = 1'b0;
        chan_a_fault = '0;
        chan_b_fault = '0;
        flags = 4'h0;
        masks = 4'h0;
        seed = $urandom(30370);
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(8'h0C, 8'h00);
        rd_chk(8'h0D, 8'h00);
        rd_chk(8'h0E, 8'h00);
        u_host.wr_reg(8'h0F, 8'hFF);
        rd_chk(8'h0F, 8'h00);
        // Corners first, then random modes with random flags and masks
        for (int i = 0; i < 24; i++)
        begin
            ctrl = (i == 0) ? 8'hFF : (i == 1) ? 8'h55 : (i == 2) ? 8'hAA : 8'($urandom);
            @(posedge sys_clk);
            flags <= 4'($urandom);
            masks <= 4'($urandom);
            u_host.wr_reg(8'h0E, ctrl);
            repeat (3) @(posedge sys_clk);
            #1 check8({4'h0, pins}, {4'h0, exp_pins(ctrl, flags)});
            rd_chk(8'h0E, ctrl);
        end
        u_host.wr_reg(8'h0C, 8'h40);
        u_host.wr_reg(8'h0D, 8'h40);
        @(posedge sys_clk);
        #1 check8({6'h00, framer}, 8'h03);
        // Each fault of each channel: edge latches once, read clears
        for (int n = 0; n < 6; n++)
        begin
            v = 3'b001 << (n % 3);
            addr = (n < 3) ? 8'h0C : 8'h0D;
            @(posedge sys_clk);
            if (n < 3)
                chan_a_fault <= v;
            else
                chan_b_fault <= v;
            repeat (5) @(posedge sys_clk);
            #1 check8({7'h00, status_interrupt}, 8'h01);
            rd_chk(addr, {2'b01, v, v});
            rd_chk(addr, {2'b01, 3'b000, v});
            check8({7'h00, status_interrupt}, 8'h00);
            @(posedge sys_clk);
            chan_a_fault <= '0;
            chan_b_fault <= '0;
            repeat (4) @(posedge sys_clk);
        end
        // Soft reset with a write that lands while busy
        u_host.wr_reg(8'h0E, 8'hFF);
        u_host.wr_reg(8'h0C, 8'h80);
        u_host.wr_reg(8'h0C, 8'h40);
        repeat (4) @(posedge sys_clk);
        rd_chk(8'h0C, 8'h00);
        rd_chk(8'h0D, 8'h40);
        rd_chk(8'h0E, 8'hF0);
        u_host.wr_reg(8'h0D, 8'h00);
        rd_chk(8'h0D, 8'h00);
        // Channel B soft reset: bit reads one while busy, A untouched
        u_host.wr_reg(8'h0C, 8'h40);
        u_host.wr_reg(8'h0E, 8'hFF);
        u_host.wr_reg(8'h0D, 8'hC0);
        rd_chk(8'h0D, 8'h80);
        rd_chk(8'h0D, 8'h00);
        rd_chk(8'h0C, 8'h40);
        rd_chk(8'h0E, 8'h0F);
        // Read lands on the very edge that latches: flag must survive
        @(posedge sys_clk);
        chan_a_fault <= 3'b100;
        @(posedge sys_clk);
        rd_chk(8'h0C, 8'h40);
        rd_chk(8'h0C, 8'h64);
        rd_chk(8'h0C, 8'h44);
        check8({7'h00, status_interrupt}, 8'h00);
        stop_test;
    end
endmodule : testbench
